// *** src/smtls_pkg.sv ***
// Package of constants and types for the servo mode and torque limit block
package smtls_pkg;
    // Clock and the millisecond time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // Parameter indices on the parameter port
    localparam logic [3:0] IDX_OPERATION_MODE = 4'h0;
    localparam logic [3:0] IDX_TL2_SWITCH = 4'h1;
    localparam logic [3:0] IDX_FE_FILTER = 4'h2;
    localparam logic [3:0] IDX_INPOS_FILTER = 4'h3;
    localparam logic [3:0] IDX_SPEED_FILTER = 4'h4;
    localparam logic [3:0] IDX_FUNCTION_F = 4'h5;
    localparam logic [3:0] IDX_SMOOTHING = 4'h6;
    localparam logic [3:0] IDX_FWD_TL2 = 4'h7;
    localparam logic [3:0] IDX_REV_TL2 = 4'h8;
    localparam logic [3:0] IDX_DIRECTION = 4'h9;
    localparam logic [3:0] IDX_FE_LEVEL = 4'hA;
    localparam logic [3:0] IDX_INPOS_RANGE = 4'hB;
    localparam logic [3:0] IDX_SPEED_RANGE = 4'hC;

    // Field positions, fields four bits wide unless a single bit or the 16-bit smoothing time constant
    localparam int CTRL_MODE_LSB = 0;
    localparam int OP_MODE_LSB = 4;
    localparam int CLOSED_LOOP_LSB = 16;
    localparam int TL2_SEL_LSB = 0;
    localparam int MAX_TL1_SEL_LSB = 4;
    localparam int SMOOTH_TC_LSB = 0;
    localparam int SMOOTH_EN_BIT = 16;
    localparam int TRAVEL_DIR_BIT = 0;
    localparam int POL_REFLECT_BIT = 1;
    localparam int CW_FWD_LIMIT2_BIT = 11;
    localparam int CW_REV_LIMIT2_BIT = 12;
    localparam int SW_TARGET_BIT = 10;
    localparam int SW_FOLLOW_ERR_BIT = 13;

    // Field values
    localparam logic [3:0] CTRL_STANDARD = 4'h0;
    localparam logic [3:0] CTRL_POINT_TABLE = 4'h6;
    localparam logic [3:0] OP_STANDARD = 4'h0;
    localparam logic [3:0] OP_LINEAR = 4'h4;
    localparam logic [3:0] OP_DIRECT_DRIVE = 4'h6;
    localparam logic [3:0] FIELD_ON = 4'h1;

    // Reset values
    localparam logic [31:0] RST_OPERATION_MODE = 32'h00003000;
    localparam logic [31:0] RST_TL2_SWITCH = 32'h00000000;
    localparam logic [15:0] RST_FILTER_TIME = 16'h0000;
    localparam logic [31:0] RST_FUNCTION_F = 32'h00000010;
    localparam logic [31:0] RST_SMOOTHING = 32'h00000000;
    localparam logic [15:0] RST_TORQUE_LIMIT2 = 16'h2710;
    localparam logic [31:0] RST_DIRECTION = 32'h00000000;
    localparam logic [31:0] RST_FE_LEVEL = 32'h0FFFFFFF;
    localparam logic [31:0] RST_RANGE = 32'h00000000;

    // Limits and special values
    localparam logic [15:0] SMOOTH_TC_MAX = 16'h03E8;
    localparam logic [15:0] TORQUE_LIMIT_MAX = 16'h2710;
    localparam logic [31:0] FE_LEVEL_DISABLE = 32'h0FFFFFFF;
    localparam logic [31:0] INPOS_ALWAYS_ON = 32'hFFFFFFFF;

    // Operation modes commanded by the controller
    typedef enum logic [3:0] {
        MODE_CSP, MODE_CSV, MODE_CST, MODE_PP, MODE_PV,
        MODE_TQ, MODE_HM, MODE_PT, MODE_JG
    } smtls_mode_e;
endpackage : smtls_pkg

// *** src/smtls_timer_if.sv ***
// Interface between the block and one of its filter timers
`timescale 1ns/1ps
interface smtls_timer_if;
    logic tick;
    logic cond;
    logic [15:0] limit_ms;
    logic status;

    modport ctrl (output tick, output cond, output limit_ms, input status);
    modport timer (input tick, input cond, input limit_ms, output status);
endinterface : smtls_timer_if

// *** src/smtls_filter_timer.sv ***
// Millisecond filter timer that qualifies one status condition
`timescale 1ns/1ps
module smtls_filter_timer (
    input wire logic clock,
    input wire logic reset,
    smtls_timer_if.timer bus
);
    typedef struct packed {
        logic [15:0] count;
        logic done;
    } smtls_timer_s;

    smtls_timer_s st_ff;
    smtls_timer_s nxt_st;

    // Count held time in ms, restart when the condition drops
    always_comb begin
        nxt_st = st_ff;
        if (!bus.cond) begin
            nxt_st.count = 16'h0000; // see (RQ18)
            nxt_st.done = 1'b0;
        end else begin
            nxt_st.done = (st_ff.count >= bus.limit_ms);
            if (bus.tick && st_ff.count != 16'hFFFF) begin
                nxt_st.count = st_ff.count + 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Status drops in the same cycle as the condition
    assign bus.status = st_ff.done & bus.cond; // see (RQ18)
endmodule : smtls_filter_timer

// *** src/smtls_servo_ctrl.sv ***
// Mode check, torque limit selection and status filtering for one axis
// Operation
// (RQ1) Control mode only 0 or 6, else alarm
// (RQ2) Operation mode 0, 4, 6; resets 0
// (RQ3) Closed loop select 0 semi, 1 full
// (RQ4) Full closed loop with linear motor alarms
// (RQ5) Smoothing 0 to 100 ms, only when enabled
// (RQ6) Limit-2 select enables command bits 11, 12
// (RQ7) Use limit 2 while selected and requested
// (RQ8) Forward limit 2 clamped to motor maximum
// (RQ9) Reverse limit 2 clamped to motor maximum
// (RQ10) Direction settings swap positive, negative limits
// (RQ11) Status bit 13 after filtered droop excess
// (RQ12) All-ones level disables following error; the code disables it at level 0FFFFFFF
// (RQ13) Following error only in csp, pp, pt, jog
// (RQ14) Status bit 10 after filtered in-position
// (RQ15) Maximum in-position range forces bit 10
// (RQ16) Profile velocity: bit 10 on speed reached
// (RQ17) Maximum torque limit 1 select, reset on
// (RQ18) Timers restart, status clears when condition drops
// (RQ19) Mode write checked, alarm held until reset
`timescale 1ns/1ps
module smtls_servo_ctrl #(
    parameter int MS_CYCLES = smtls_pkg::MS_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic param_wr_en,
    input wire logic param_rd_en,
    input wire logic [3:0] param_index,
    input wire logic [31:0] param_wdata,
    output logic [31:0] param_rdata,
    output logic param_rvalid,
    input wire smtls_pkg::smtls_mode_e op_mode,
    input wire logic [15:0] control_word,
    input wire logic [15:0] primary_fwd_limit,
    input wire logic [15:0] primary_rev_limit,
    input wire logic [15:0] max_torque_limit1,
    input wire logic [15:0] motor_max_torque,
    input wire logic [31:0] droop_count,
    input wire logic [31:0] position_error,
    input wire logic [31:0] speed_error,
    output logic [15:0] status_word,
    output logic [15:0] positive_torque_limit,
    output logic [15:0] negative_torque_limit,
    output logic [15:0] smoothing_time_constant,
    output logic parameter_error_alarm
);
    typedef struct packed {
        logic [31:0] operation_mode_config;
        logic [31:0] torque_limit2_switch_config;
        logic [15:0] following_error_filter_time;
        logic [15:0] in_position_filter_time;
        logic [15:0] speed_reached_filter_time;
        logic [31:0] function_select_f;
        logic [31:0] smoothing_config;
        logic [15:0] forward_torque_limit_two;
        logic [15:0] reverse_torque_limit_two;
        logic [31:0] direction_config;
        logic [31:0] following_error_level;
        logic [31:0] in_position_range;
        logic [31:0] speed_reached_range;
        logic alarm;
        logic [31:0] div_count;
        logic tick;
        logic [15:0] pos_limit;
        logic [15:0] neg_limit;
        logic [15:0] status;
        logic [15:0] smooth_tc;
        logic [31:0] rdata;
        logic rvalid;
    } smtls_state_s;

    smtls_state_s st_ff;
    smtls_state_s nxt_st;

    // Magnitude of a two's complement value
    function automatic logic [31:0] smtls_mag(input logic [31:0] v);
        smtls_mag = v[31] ? (~v + 32'h00000001) : v;
    endfunction : smtls_mag

    // Smaller of two limits
    function automatic logic [15:0] smtls_min(input logic [15:0] a,
                                              input logic [15:0] b);
        smtls_min = (a < b) ? a : b;
    endfunction : smtls_min

    // Mode value legality of a whole operation mode word
    function automatic logic smtls_mode_ok(input logic [31:0] v);
        logic [3:0] ctrl;
        logic [3:0] op;
        logic [3:0] loop;
        ctrl = v[smtls_pkg::CTRL_MODE_LSB +: 4];
        op = v[smtls_pkg::OP_MODE_LSB +: 4];
        loop = v[smtls_pkg::CLOSED_LOOP_LSB +: 4]; // see (RQ3)
        smtls_mode_ok = (ctrl == smtls_pkg::CTRL_STANDARD ||
                         ctrl == smtls_pkg::CTRL_POINT_TABLE) &&
                        !(loop == smtls_pkg::FIELD_ON &&
                          op == smtls_pkg::OP_LINEAR);
    endfunction : smtls_mode_ok

    // Stored word for a parameter index
    function automatic logic [31:0] smtls_read(input smtls_state_s s,
                                               input logic [3:0] idx);
        smtls_read = 32'h00000000;
        if (idx == smtls_pkg::IDX_OPERATION_MODE) begin
            smtls_read = s.operation_mode_config;
        end else if (idx == smtls_pkg::IDX_TL2_SWITCH) begin
            smtls_read = s.torque_limit2_switch_config;
        end else if (idx == smtls_pkg::IDX_FE_FILTER) begin
            smtls_read = {16'h0000, s.following_error_filter_time};
        end else if (idx == smtls_pkg::IDX_INPOS_FILTER) begin
            smtls_read = {16'h0000, s.in_position_filter_time};
        end else if (idx == smtls_pkg::IDX_SPEED_FILTER) begin
            smtls_read = {16'h0000, s.speed_reached_filter_time};
        end else if (idx == smtls_pkg::IDX_FUNCTION_F) begin
            smtls_read = s.function_select_f;
        end else if (idx == smtls_pkg::IDX_SMOOTHING) begin
            smtls_read = s.smoothing_config;
        end else if (idx == smtls_pkg::IDX_FWD_TL2) begin
            smtls_read = {16'h0000, s.forward_torque_limit_two};
        end else if (idx == smtls_pkg::IDX_REV_TL2) begin
            smtls_read = {16'h0000, s.reverse_torque_limit_two};
        end else if (idx == smtls_pkg::IDX_DIRECTION) begin
            smtls_read = s.direction_config;
        end else if (idx == smtls_pkg::IDX_FE_LEVEL) begin
            smtls_read = s.following_error_level;
        end else if (idx == smtls_pkg::IDX_INPOS_RANGE) begin
            smtls_read = s.in_position_range;
        end else if (idx == smtls_pkg::IDX_SPEED_RANGE) begin
            smtls_read = s.speed_reached_range;
        end
    endfunction : smtls_read

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    // Filter timer links: 0 following error, 1 in-position, 2 speed
    smtls_timer_if tif[3] ();
    logic cond_w [3];
    logic [15:0] limit_w [3];
    logic stat_w [3];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_timer
            assign tif[gi].tick = st_ff.tick;
            assign tif[gi].cond = cond_w[gi];
            assign tif[gi].limit_ms = limit_w[gi];
            assign stat_w[gi] = tif[gi].status;
            smtls_filter_timer u_timer (
                .clock(clock),
                .reset(reset),
                .bus(tif[gi].timer)
            );
        end
    endgenerate

    // Mode groups and monitored conditions
    logic fe_mode;
    logic inpos_mode;
    logic pv_mode;
    always_comb begin
        fe_mode = (op_mode == smtls_pkg::MODE_CSP) ||
                  (op_mode == smtls_pkg::MODE_PP) ||
                  (op_mode == smtls_pkg::MODE_PT) ||
                  (op_mode == smtls_pkg::MODE_JG); // see (RQ13)
        inpos_mode = (op_mode == smtls_pkg::MODE_PP) ||
                     (op_mode == smtls_pkg::MODE_PT) ||
                     (op_mode == smtls_pkg::MODE_JG); // see (RQ14)
        pv_mode = (op_mode == smtls_pkg::MODE_PV); // see (RQ16)
        cond_w[0] = fe_mode &&
                    (st_ff.following_error_level !=
                     smtls_pkg::FE_LEVEL_DISABLE) && // see (RQ12)
                    (smtls_mag(droop_count) >=
                     st_ff.following_error_level); // see (RQ11)
        cond_w[1] = inpos_mode &&
                    (smtls_mag(position_error) <=
                     st_ff.in_position_range); // see (RQ14)
        cond_w[2] = pv_mode &&
                    (smtls_mag(speed_error) <=
                     st_ff.speed_reached_range); // see (RQ16)
        limit_w[0] = st_ff.following_error_filter_time;
        limit_w[1] = st_ff.in_position_filter_time;
        limit_w[2] = st_ff.speed_reached_filter_time;
    end

    // Next state: parameter writes, checks, limits and status
    logic fwd_sel;
    logic rev_sel;
    logic swap;
    logic [15:0] fwd_lim;
    logic [15:0] rev_lim;
    logic target_bit;
    always_comb begin
        nxt_st = st_ff;
        // Millisecond enable from the clock divider
        nxt_st.tick = (st_ff.div_count == MS_LAST);
        nxt_st.div_count = nxt_st.tick ? 32'h00000000
                                       : st_ff.div_count + 32'h00000001;
        // Parameter writes
        if (param_wr_en) begin
            if (param_index == smtls_pkg::IDX_OPERATION_MODE) begin
                nxt_st.operation_mode_config = param_wdata; // see (RQ2)
                if (!smtls_mode_ok(param_wdata)) begin
                    nxt_st.alarm = 1'b1; // see (RQ1) see (RQ4) see (RQ19)
                end
            end else if (param_index == smtls_pkg::IDX_TL2_SWITCH) begin
                nxt_st.torque_limit2_switch_config = param_wdata;
            end else if (param_index == smtls_pkg::IDX_FE_FILTER) begin
                nxt_st.following_error_filter_time = param_wdata[15:0];
            end else if (param_index == smtls_pkg::IDX_INPOS_FILTER) begin
                nxt_st.in_position_filter_time = param_wdata[15:0];
            end else if (param_index == smtls_pkg::IDX_SPEED_FILTER) begin
                nxt_st.speed_reached_filter_time = param_wdata[15:0];
            end else if (param_index == smtls_pkg::IDX_FUNCTION_F) begin
                nxt_st.function_select_f = param_wdata; // see (RQ17)
            end else if (param_index == smtls_pkg::IDX_SMOOTHING) begin
                nxt_st.smoothing_config = param_wdata;
            end else if (param_index == smtls_pkg::IDX_FWD_TL2) begin
                nxt_st.forward_torque_limit_two = smtls_min(
                    param_wdata[15:0], smtls_pkg::TORQUE_LIMIT_MAX);
            end else if (param_index == smtls_pkg::IDX_REV_TL2) begin
                nxt_st.reverse_torque_limit_two = smtls_min(
                    param_wdata[15:0], smtls_pkg::TORQUE_LIMIT_MAX);
            end else if (param_index == smtls_pkg::IDX_DIRECTION) begin
                nxt_st.direction_config = param_wdata;
            end else if (param_index == smtls_pkg::IDX_FE_LEVEL) begin
                nxt_st.following_error_level = param_wdata;
            end else if (param_index == smtls_pkg::IDX_INPOS_RANGE) begin
                nxt_st.in_position_range = param_wdata;
            end else if (param_index == smtls_pkg::IDX_SPEED_RANGE) begin
                nxt_st.speed_reached_range = param_wdata;
            end
        end
        // Parameter read answer
        nxt_st.rvalid = param_rd_en;
        if (param_rd_en) begin
            nxt_st.rdata = smtls_read(st_ff, param_index);
        end
        // Torque limit 2 selection by command word bits
        fwd_sel = (st_ff.torque_limit2_switch_config[
                       smtls_pkg::TL2_SEL_LSB +: 4] == smtls_pkg::FIELD_ON) &&
                  control_word[smtls_pkg::CW_FWD_LIMIT2_BIT]; // see (RQ6)
        rev_sel = (st_ff.torque_limit2_switch_config[
                       smtls_pkg::TL2_SEL_LSB +: 4] == smtls_pkg::FIELD_ON) &&
                  control_word[smtls_pkg::CW_REV_LIMIT2_BIT]; // see (RQ6)
        fwd_lim = fwd_sel ? st_ff.forward_torque_limit_two
                          : primary_fwd_limit; // see (RQ7)
        rev_lim = rev_sel ? st_ff.reverse_torque_limit_two
                          : primary_rev_limit; // see (RQ7)
        // Clamp to the motor maximum, zero gives no torque
        fwd_lim = smtls_min(fwd_lim, motor_max_torque); // see (RQ8)
        rev_lim = smtls_min(rev_lim, motor_max_torque); // see (RQ9)
        if (st_ff.function_select_f[smtls_pkg::MAX_TL1_SEL_LSB +: 4] ==
            smtls_pkg::FIELD_ON) begin
            fwd_lim = smtls_min(fwd_lim, max_torque_limit1); // see (RQ17)
            rev_lim = smtls_min(rev_lim, max_torque_limit1); // see (RQ17)
        end
        // Direction settings swap the limit objects
        swap = st_ff.direction_config[smtls_pkg::TRAVEL_DIR_BIT] ^
               st_ff.direction_config[smtls_pkg::POL_REFLECT_BIT];
        nxt_st.pos_limit = swap ? rev_lim : fwd_lim; // see (RQ10)
        nxt_st.neg_limit = swap ? fwd_lim : rev_lim; // see (RQ10)
        // Smoothing time constant, clamped and gated by enable
        nxt_st.smooth_tc = st_ff.smoothing_config[smtls_pkg::SMOOTH_EN_BIT]
            ? smtls_min(st_ff.smoothing_config[smtls_pkg::SMOOTH_TC_LSB +: 16],
                        smtls_pkg::SMOOTH_TC_MAX)
            : 16'h0000; // see (RQ5)
        // Status word bits
        target_bit = pv_mode ? stat_w[2] // see (RQ16)
            : (inpos_mode &&
               st_ff.in_position_range == smtls_pkg::INPOS_ALWAYS_ON)
              || stat_w[1]; // see (RQ14) see (RQ15)
        nxt_st.status = 16'h0000;
        nxt_st.status[smtls_pkg::SW_TARGET_BIT] = target_bit;
        nxt_st.status[smtls_pkg::SW_FOLLOW_ERR_BIT] = stat_w[0]; // see (RQ11)
    end

    // State register with its reset values
    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.operation_mode_config <= smtls_pkg::RST_OPERATION_MODE;
            st_ff.torque_limit2_switch_config <= smtls_pkg::RST_TL2_SWITCH;
            st_ff.following_error_filter_time <= smtls_pkg::RST_FILTER_TIME;
            st_ff.in_position_filter_time <= smtls_pkg::RST_FILTER_TIME;
            st_ff.speed_reached_filter_time <= smtls_pkg::RST_FILTER_TIME;
            st_ff.function_select_f <= smtls_pkg::RST_FUNCTION_F;
            st_ff.smoothing_config <= smtls_pkg::RST_SMOOTHING;
            st_ff.forward_torque_limit_two <= smtls_pkg::RST_TORQUE_LIMIT2;
            st_ff.reverse_torque_limit_two <= smtls_pkg::RST_TORQUE_LIMIT2;
            st_ff.direction_config <= smtls_pkg::RST_DIRECTION;
            st_ff.following_error_level <= smtls_pkg::RST_FE_LEVEL;
            st_ff.in_position_range <= smtls_pkg::RST_RANGE;
            st_ff.speed_reached_range <= smtls_pkg::RST_RANGE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign param_rdata = st_ff.rdata;
    assign param_rvalid = st_ff.rvalid;
    assign status_word = st_ff.status;
    assign positive_torque_limit = st_ff.pos_limit;
    assign negative_torque_limit = st_ff.neg_limit;
    assign smoothing_time_constant = st_ff.smooth_tc;
    assign parameter_error_alarm = st_ff.alarm;
endmodule : smtls_servo_ctrl

// *** dv/smtls_properties.sv ***
// Port-level checker for the servo mode and torque limit block
`timescale 1ns/1ps
module smtls_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic param_wr_en,
    input wire logic param_rd_en,
    input wire logic [3:0] param_index,
    input wire logic [31:0] param_wdata,
    input wire logic param_rvalid,
    input wire smtls_pkg::smtls_mode_e op_mode,
    input wire logic [15:0] motor_max_torque,
    input wire logic [15:0] status_word,
    input wire logic [15:0] positive_torque_limit,
    input wire logic [15:0] negative_torque_limit,
    input wire logic [15:0] smoothing_time_constant,
    input wire logic parameter_error_alarm
);
    logic mode_wr;
    logic bad_ctrl;
    logic lin_full;
    // Decoded mode-field writes
    assign mode_wr = param_wr_en && param_index == 4'h0;
    assign bad_ctrl = !(param_wdata[3:0] inside {4'h0, 4'h6});
    assign lin_full = param_wdata[19:16] == 4'h1 && param_wdata[7:4] == 4'h4;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_alarm_held: assert property (
        parameter_error_alarm |=> parameter_error_alarm)
        else $error("alarm dropped without reset");
    a_bad_ctrl: assert property (
        mode_wr && bad_ctrl |-> ##[1:2] parameter_error_alarm)
        else $error("illegal control mode not flagged");
    a_good_ctrl_quiet: assert property (
        mode_wr && !bad_ctrl && !lin_full
        && !parameter_error_alarm |=> !parameter_error_alarm)
        else $error("legal mode write raised alarm");
    a_linear_full: assert property (
        mode_wr && lin_full |-> ##[1:2] parameter_error_alarm)
        else $error("full loop with linear motor not flagged");
    a_limit_clamp: assert property (
        positive_torque_limit <= $past(motor_max_torque)
        && negative_torque_limit <= $past(motor_max_torque))
        else $error("torque limit above motor maximum");
    a_smooth_max: assert property (smoothing_time_constant <= 16'h03E8)
        else $error("smoothing constant above range");
    a_fe_mode_gate: assert property (
        !(op_mode inside {smtls_pkg::MODE_CSP,
        smtls_pkg::MODE_PP, smtls_pkg::MODE_PT, smtls_pkg::MODE_JG})
        && $past(op_mode) == op_mode && $past(op_mode, 2) == op_mode
        |-> !status_word[13])
        else $error("following error outside its modes");
    a_read_answer: assert property (param_rd_en |=> param_rvalid)
        else $error("read not answered");
endmodule : smtls_properties
bind smtls_servo_ctrl smtls_properties i_props (
    .clock(clock), .reset(reset), .param_wr_en(param_wr_en),
    .param_rd_en(param_rd_en), .param_index(param_index),
    .param_wdata(param_wdata), .param_rvalid(param_rvalid),
    .op_mode(op_mode), .motor_max_torque(motor_max_torque),
    .status_word(status_word), .positive_torque_limit(positive_torque_limit),
    .negative_torque_limit(negative_torque_limit),
    .smoothing_time_constant(smoothing_time_constant),
    .parameter_error_alarm(parameter_error_alarm)
);

// *** dv/smtls_ctrl_model.sv ***
// Controller model that builds the command word every cycle
`timescale 1ns/1ps
module smtls_ctrl_model (
    input wire logic clock,
    input wire logic fwd_req,
    input wire logic rev_req,
    output logic [15:0] control_word
);
    logic [15:0] noise_ff = 16'h0000;
    // Other bits churn; limit requests sit on bits 11 and 12
    always @(posedge clock) begin
        noise_ff <= ~noise_ff ^ 16'h5A5A;
        control_word <= (noise_ff & 16'hE7FF) |
                        {3'h0, rev_req, fwd_req, 11'h0};
    end
endmodule : smtls_ctrl_model

// *** dv/smtls_servo_ctrl_tb.sv ***
// Self-checking bench for the servo mode and torque limit block
`timescale 1ns/1ps
module smtls_servo_ctrl_tb;
    logic clock = 0, reset = 1, wr = 0, rd = 0, fq = 0, rq = 0, rv, alarm;
    logic [3:0] idx = 4'h0;
    logic [31:0] wd = 0, de = 0, pe = 0, se = 0, rdat, expq[$];
    logic [15:0] cw, sw, ptl, ntl, stc, r, pfl = 16'h0064;
    logic [15:0] prl = 16'h00C8, mtl = 16'h2710, mmt = 16'h2710;
    smtls_pkg::smtls_mode_e mode = smtls_pkg::MODE_CSP;
    int miscompares = 0, n_compared = 0;
    // Clock of 10 ns
    initial forever #5 clock = ~clock;
    smtls_servo_ctrl #(.MS_CYCLES(10)) i_dut (.clock(clock), .reset(reset),
        .param_wr_en(wr), .param_rd_en(rd), .param_index(idx),
        .param_wdata(wd), .param_rdata(rdat), .param_rvalid(rv),
        .op_mode(mode), .control_word(cw), .primary_fwd_limit(pfl),
        .primary_rev_limit(prl), .max_torque_limit1(mtl),
        .motor_max_torque(mmt), .droop_count(de), .position_error(pe),
        .speed_error(se), .status_word(sw), .positive_torque_limit(ptl),
        .negative_torque_limit(ntl), .smoothing_time_constant(stc),
        .parameter_error_alarm(alarm));
    smtls_ctrl_model i_ctrl (.clock(clock), .fwd_req(fq), .rev_req(rq),
        .control_word(cw));
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle
    task automatic wr_p(input logic [3:0] i, input logic [31:0] d);
        @(negedge clock);
        wr = 1;
        idx = i;
        wd = d;
        @(negedge clock);
        wr = 0;
    endtask : wr_p
    task automatic rd_p(input logic [3:0] i, input logic [31:0] e);
        @(negedge clock);
        rd = 1;
        idx = i;
        expq.push_back(e);
        @(negedge clock);
        rd = 0;
    endtask : rd_p
    task automatic wait_sw(input int b, input logic v, input int n);
        for (int k = 0; k < n && sw[b] !== v; k++) @(negedge clock);
        chk(sw[b], v, "status");
    endtask : wait_sw
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // Read answers taken off the queue in order
    always @(negedge clock) begin
        if (rv === 1'b1 && expq.size() > 0) begin
            chk(rdat, expq.pop_front(), "read");
        end
    end
    // Watchdog against a hang
    initial begin
        #100us;
        miscompares++;
        $display("CHECK FAILED %0t timeout", $time);
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(893));
        settle(20);
        reset = 0;
        rd_p(4'h0, 32'h00003000);
        rd_p(4'h1, 32'h0);
        rd_p(4'h5, 32'h10);
        rd_p(4'h7, 32'h2710);
        rd_p(4'hF, 32'h0);
        $display("test registers done");
        r = 16'($urandom_range(4000, 1));
        fq = 1;
        rq = 1;
        wr_p(4'h7, {16'h0, r});
        wr_p(4'h8, 32'h3000);
        settle(3);
        chk(ptl, pfl, "fwd primary");
        chk(ntl, prl, "rev primary");
        rd_p(4'h8, 32'h2710);
        wr_p(4'h1, 32'h1);
        settle(3);
        chk(ptl, r, "fwd limit2");
        chk(ntl, 16'h2710, "rev limit2");
        fq = 0;
        mmt = 16'h0100;
        settle(4);
        chk(ptl, pfl, "fwd back");
        chk(ntl, 16'h0100, "rev clamp");
        wr_p(4'h9, 32'h1);
        settle(3);
        chk({ptl, ntl}, {16'h0100, pfl}, "swap");
        wr_p(4'h9, 32'h3);
        mmt = 16'h2710;
        mtl = 16'h0050;
        settle(4);
        chk({ptl, ntl}, {16'h0050, 16'h0050}, "max limit1");
        wr_p(4'h5, 32'h0);
        settle(3);
        chk(ptl, pfl, "limit1 off");
        $display("test torque limits done");
        wr_p(4'h6, 32'h1F4);
        settle(3);
        chk(stc, 16'h0, "smooth off");
        wr_p(4'h6, 32'h101F4);
        settle(3);
        chk(stc, 16'h01F4, "smooth on");
        $display("test smoothing done");
        wr_p(4'hA, 32'h64);
        wr_p(4'h2, 32'h3);
        de = 32'hC8;
        settle(15);
        chk(sw[13], 1'b0, "fe early");
        wait_sw(13, 1'b1, 40);
        de = 32'h0;
        wait_sw(13, 1'b0, 2);
        mode = smtls_pkg::MODE_PV;
        de = 32'hC8;
        settle(60);
        chk(sw[13], 1'b0, "fe in pv");
        mode = smtls_pkg::MODE_CSP;
        wr_p(4'hA, 32'h0FFFFFFF);
        settle(60);
        chk(sw[13], 1'b0, "fe disabled");
        mode = smtls_pkg::MODE_PP;
        wr_p(4'hB, 32'hA);
        wr_p(4'h3, 32'h2);
        pe = 32'h32;
        settle(30);
        chk(sw[10], 1'b0, "inpos out");
        pe = 32'h5;
        wait_sw(10, 1'b1, 40);
        pe = 32'h32;
        wr_p(4'hB, 32'hFFFFFFFF);
        wait_sw(10, 1'b1, 3);
        mode = smtls_pkg::MODE_PV;
        wr_p(4'hC, 32'h14);
        se = 32'h64;
        settle(20);
        chk(sw[10], 1'b0, "speed out");
        se = 32'h3;
        wait_sw(10, 1'b1, 10);
        $display("test status done");
        for (int v = 0; v < 16; v++) begin
            reset = 1;
            settle(2);
            reset = 0;
            wr_p(4'h0, v);
            settle(2);
            chk(alarm, v != 0 && v != 6, "ctrl field");
        end
        reset = 1;
        settle(2);
        reset = 0;
        wr_p(4'h0, 32'h00010060);
        settle(2);
        chk(alarm, 1'b0, "full loop direct");
        wr_p(4'h0, 32'h00010040);
        settle(5);
        chk(alarm, 1'b1, "linear full");
        $display("test alarms done");
        summarize();
    end
endmodule : smtls_servo_ctrl_tb
